// ==== verilog/pcg_regs.vh ====
// Register offsets, field positions and reset values of the clock block
`ifndef PCG_REGS_VH
`define PCG_REGS_VH
`define PCG_ADDR_W        12
`define PCG_OFF_PLL_SETTINGS_READBACK    12'h064
`define PCG_OFF_RUNGATE   12'h100
`define PCG_OFF_SLPGATE   12'h110
`define PCG_OFF_DSLGATE   12'h120
`define PCG_OFF_RCC       12'h060
`define PCG_OFF_IRQSTAT   12'h140
`define PCG_OFF_IRQMASK   12'h144
`define PCG_OFF_FAULT     12'h148
`define PCG_RCC_CRYSTAL_SELECT_LSB  6
`define PCG_RCC_CRYSTAL_SELECT_MSB  9
`define PCG_RCC_ACG       27
`define PCG_RCC_RESET     32'h000002c0
`define PCG_GATE_RESET    32'h00000001
`define PCG_GATE_RWMASK   32'h00110f0f
`define PCG_GATE_UNITS    32'h0011000f
`define PCG_ADSPD_RESET   32'h00000100
`define PCG_OD_LSB        14
`define PCG_F_LSB         5
`define PCG_MODE_RUN      2'h0
`define PCG_MODE_SLEEP    2'h1
`define PCG_MODE_DEEP     2'h2
`define PCG_IRQ_XTALCHG   0
`define PCG_IRQ_FAULT     1
`endif

// ==== verilog/pcg_clock_gate.v ====
// PLL translation readback and per-mode peripheral clock gating
`timescale 1ns/1ps
`include "pcg_regs.vh"
// Contract
// - After reset the PLL readback holds settings for the reset crystal.
// - Changing crystal_select recomputes the PLL readback settings.
// - Bits 13:5 show the nine-bit multiplying value; read-only.
// - Reserved bits read zero; software preserves them.
// - A set gating bit clocks its unit; clear leaves it unclocked.
// - Access to a gated-off unit answers with a bus fault.
// - Gating bits reset to zero unless documented otherwise.
// - Run, sleep and deep-sleep gating registers at 0x100, 0x110, 0x120.
// - Sleep registers apply only with auto_clock_gating set; else run.
// - Bit positions without units stay reserved, read-only zero, except adc_max_speed bits 11:8.
// - Bit 16 gates the sampler unit.
// - Bits 3, 2, 1 gate watchdog, trace output, serial debug.
// - Bit 0 gates the boundary-scan port and resets to one.
module pcg_clock_gate
(
    sys_clk,
    rst_n,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    power_mode,
    unit_sel,
    unit_access,
    unit_fault,
    unit_clk_en,
    pll_output_divide,
    pll_multiplier,
    pll_input_divide,
    adc_max_speed,
    irq
);
    input  wire                     sys_clk;
    input  wire                     rst_n;
    input  wire [`PCG_ADDR_W-1:0]   reg_addr;
    input  wire [31:0]              reg_wdata;
    input  wire                     reg_wr;
    input  wire                     reg_rd;
    output reg  [31:0]              reg_rdata;
    input  wire [1:0]               power_mode;
    input  wire [4:0]               unit_sel;
    input  wire                     unit_access;
    output wire                     unit_fault;
    output wire [31:0]              unit_clk_en;
    output wire [1:0]               pll_output_divide;
    output wire [8:0]               pll_multiplier;
    output wire [4:0]               pll_input_divide;
    output wire [3:0]               adc_max_speed;
    output wire                     irq;

    reg  [31:0] rcc_r;
    reg  [31:0] gate_r [0:2];
    reg  [15:0] pll_r;
    reg  [1:0]  irq_stat_r;
    reg  [1:0]  irq_mask_r;
    reg  [31:0] fault_cnt_r;
    reg  [31:0] gate_sel;
    reg  [31:0] rdata_nxt;
    wire [3:0]  crystal_select;
    integer     i;

    // Crystal code to PLL settings: {output divide, F, R}
    function [15:0] pll_lookup;
        input [3:0] code;
        begin
            case (code)
                4'h4:    pll_lookup = {2'h0, 9'h0c6, 5'h03};
                4'h5:    pll_lookup = {2'h0, 9'h0c2, 5'h03};
                4'h6:    pll_lookup = {2'h0, 9'h0c6, 5'h04};
                4'h7:    pll_lookup = {2'h0, 9'h0ba, 5'h04};
                4'h8:    pll_lookup = {2'h0, 9'h0d2, 5'h05};
                4'h9:    pll_lookup = {2'h0, 9'h0c6, 5'h05};
                4'ha:    pll_lookup = {2'h0, 9'h0c0, 5'h05};
                4'hb:    pll_lookup = {2'h0, 9'h0c6, 5'h06};
                4'hc:    pll_lookup = {2'h0, 9'h0c1, 5'h06};
                4'hd:    pll_lookup = {2'h0, 9'h0c9, 5'h08};
                4'he:    pll_lookup = {2'h0, 9'h0c6, 5'h08};
                4'hf:    pll_lookup = {2'h0, 9'h0c3, 5'h08};
                default: pll_lookup = 16'h0000;
            endcase
        end
    endfunction

    function [1:0] gate_index;
        input [`PCG_ADDR_W-1:0] a;
        begin
            case (a)
                `PCG_OFF_RUNGATE: gate_index = 2'h0;
                `PCG_OFF_SLPGATE: gate_index = 2'h1;
                `PCG_OFF_DSLGATE: gate_index = 2'h2;
                default:          gate_index = 2'h3;
            endcase
        end
    endfunction

    assign crystal_select = rcc_r[`PCG_RCC_CRYSTAL_SELECT_MSB:`PCG_RCC_CRYSTAL_SELECT_LSB];

    // Effective gate set for current power mode
    always @*
    begin
        gate_sel = gate_r[0];
        if (rcc_r[`PCG_RCC_ACG])
        begin
            if (power_mode == `PCG_MODE_SLEEP)
                gate_sel = gate_r[1];
            else if (power_mode == `PCG_MODE_DEEP)
                gate_sel = gate_r[2];
        end
    end

    assign unit_clk_en = gate_sel & `PCG_GATE_UNITS;
    assign unit_fault  = unit_access & ~unit_clk_en[unit_sel];
    assign adc_max_speed = gate_r[0][11:8];
    assign pll_output_divide = pll_r[15:14];
    assign pll_multiplier    = pll_r[13:5];
    assign pll_input_divide  = pll_r[4:0];
    assign irq = |(irq_stat_r & irq_mask_r);

    always @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            rcc_r       <= `PCG_RCC_RESET;
            pll_r       <= 16'h0000;
            irq_stat_r  <= 2'h0;
            irq_mask_r  <= 2'h0;
            fault_cnt_r <= 32'h00000000;
            for (i = 0; i < 3; i = i + 1)
                gate_r[i] <= `PCG_GATE_RESET | `PCG_ADSPD_RESET;
        end
        else
        begin
            pll_r <= pll_lookup(crystal_select);
            if (reg_wr && reg_addr == `PCG_OFF_RCC)
                rcc_r <= reg_wdata;
            if (reg_wr && gate_index(reg_addr) != 2'h3)
                gate_r[gate_index(reg_addr)] <=
                    reg_wdata & `PCG_GATE_RWMASK;
            if (reg_wr && reg_addr == `PCG_OFF_IRQMASK)
                irq_mask_r <= reg_wdata[1:0];
            if (unit_fault)
                fault_cnt_r <= fault_cnt_r + 32'h00000001;
            else if (reg_rd && reg_addr == `PCG_OFF_FAULT)
                fault_cnt_r <= 32'h00000000;
            // Read clears status; new events win
            irq_stat_r <= (reg_rd && reg_addr == `PCG_OFF_IRQSTAT)
                          ? 2'h0 : irq_stat_r;
            if (reg_wr && reg_addr == `PCG_OFF_RCC &&
                reg_wdata[`PCG_RCC_CRYSTAL_SELECT_MSB:`PCG_RCC_CRYSTAL_SELECT_LSB] != crystal_select)
                irq_stat_r[`PCG_IRQ_XTALCHG] <= 1'b1;
            if (unit_fault)
                irq_stat_r[`PCG_IRQ_FAULT] <= 1'b1;
        end
    end

    // Read mux; writes to the readback register are ignored
    always @*
    begin
        case (reg_addr)
            `PCG_OFF_PLL_SETTINGS_READBACK:  rdata_nxt = {16'h0000, pll_r};
            `PCG_OFF_RCC:     rdata_nxt = rcc_r;
            `PCG_OFF_RUNGATE: rdata_nxt = gate_r[0];
            `PCG_OFF_SLPGATE: rdata_nxt = gate_r[1];
            `PCG_OFF_DSLGATE: rdata_nxt = gate_r[2];
            `PCG_OFF_IRQSTAT: rdata_nxt = {30'h0, irq_stat_r};
            `PCG_OFF_IRQMASK: rdata_nxt = {30'h0, irq_mask_r};
            `PCG_OFF_FAULT:   rdata_nxt = fault_cnt_r;
            default:          rdata_nxt = 32'h00000000;
        endcase
    end

    always @(posedge sys_clk)
    begin
        if (!rst_n)
            reg_rdata <= 32'h00000000;
        else if (reg_rd)
            reg_rdata <= rdata_nxt;
        else
            reg_rdata <= 32'h00000000;
    end
endmodule // pcg_clock_gate

// ==== tb/pcg_clock_gate_props.sv ====
// Assertion checker for the clock gating block
`timescale 1ns/1ps
module pcg_gate_props
(
    input wire        sys_clk,
    input wire        rst_n,
    input wire [11:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [31:0] reg_rdata,
    input wire [1:0]  power_mode,
    input wire [4:0]  unit_sel,
    input wire        unit_access,
    input wire        unit_fault,
    input wire [31:0] unit_clk_en,
    input wire [1:0]  pll_output_divide,
    input wire [8:0]  pll_multiplier,
    input wire [4:0]  pll_input_divide
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence run_wr;
        reg_wr && reg_addr == 12'h100 && power_mode == 2'h0;
    endsequence
    sequence pll_rd;
        reg_rd && reg_addr == 12'h064;
    endsequence
    fault_match_a: assert property (
        unit_fault == (unit_access && !unit_clk_en[unit_sel]))
        else $error("unit fault mismatch");
    spare_bits_a: assert property ((unit_clk_en & ~32'h0011000f) == 0)
        else $error("clock enable on a spare bit");
    reset_gate_a: assert property ($rose(rst_n) |-> unit_clk_en == 32'h1)
        else $error("enables after reset wrong");
    run_write_a: assert property (run_wr |=> power_mode != 2'h0 ||
        unit_clk_en == ($past(reg_wdata) & 32'h0011000f))
        else $error("run gate write not applied");
    pll_read_a: assert property (pll_rd |=> reg_rdata == {16'h0,
        $past({pll_output_divide, pll_multiplier, pll_input_divide})})
        else $error("pll readback mismatch");
    pll_steady_a: assert property ($past(rst_n, 3) &&
        $changed({pll_output_divide, pll_multiplier, pll_input_divide})
        |-> $past(reg_wr && reg_addr == 12'h060, 2))
        else $error("pll settings changed without crystal write");
    pll_ro_a: assert property (reg_wr && reg_addr == 12'h064 &&
        !$past(reg_wr) |=> $stable({pll_output_divide, pll_multiplier}))
        else $error("pll settings altered by write");
    gate_spare_a: assert property (reg_rd && reg_addr == 12'h100 |=>
        (reg_rdata & ~32'h00110f0f) == 0)
        else $error("spare gate bits read nonzero");
endmodule // pcg_gate_props
bind pcg_clock_gate pcg_gate_props u_props (.*);

// ==== tb/pcg_clock_gate_test.sv ====
// Self-checking bench for the clock gating block
`timescale 1ns/1ps
module pcg_clock_gate_test;
    reg         sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, rd_d = 0;
    reg         unit_access = 0;
    reg  [11:0] reg_addr = 0, a;
    reg  [31:0] reg_wdata = 0, g [0:2];
    reg  [1:0]  power_mode = 0;
    reg  [4:0]  unit_sel = 0;
    wire [31:0] reg_rdata, unit_clk_en;
    wire        unit_fault, irq;
    integer     n_fail = 0, tests_run = 0, seed = 97, i;
    reg  [31:0] exp_q [$];
    always #5 sys_clk = ~sys_clk;
    pcg_clock_gate DUT (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .power_mode(power_mode), .unit_sel(unit_sel),
        .unit_access(unit_access), .unit_fault(unit_fault),
        .unit_clk_en(unit_clk_en), .pll_output_divide(), .pll_multiplier(),
        .pll_input_divide(), .adc_max_speed(), .irq(irq));
    task check(input [31:0] seen, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp)
            begin
                n_fail = n_fail + 1;
                $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task bus(input w, input [11:0] ad, input [31:0] d);
        begin
            @(posedge sys_clk);
            reg_wr <= w;
            reg_rd <= !w;
            reg_addr <= ad;
            reg_wdata <= d;
            if (!w) exp_q.push_back(d);
            @(posedge sys_clk);
            reg_wr <= 0;
            reg_rd <= 0;
        end
    endtask
    task summarize;
        begin
            $display("comparisons %0d mismatches %0d", tests_run, n_fail);
            if (n_fail == 0 && tests_run > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    always @(posedge sys_clk)
    begin
        if (rd_d) check(reg_rdata, exp_q.pop_front());
        rd_d <= reg_rd;
    end
    initial
    begin
        repeat (5) @(posedge sys_clk);
        rst_n <= 1;
        a = 12'h100;
        for (i = 0; i < 3; i = i + 1)
        begin
            bus(0, a, 32'h101);
            g[i] = $random(seed) & 32'hfffffffe;
            bus(1, a, g[i]);
            bus(0, a, g[i] & 32'h00110f0f);
            a = a + 12'h10;
        end
        bus(0, 12'h064, 32'h000018c6);
        bus(1, 12'h064, 32'hffffffff);
        bus(0, 12'h064, 32'h000018c6);
        $display("gate registers done");
        bus(1, 12'h144, 32'h3);
        for (i = 0; i < 32; i = i + 1)
        begin
            // Only bits 0-3, 16 and 20 have units behind them
            a[0] = (i < 4) || (i == 16) || (i == 20);
            @(posedge sys_clk);
            unit_sel <= i[4:0];
            unit_access <= 1;
            @(negedge sys_clk);
            check(unit_fault, !(g[0][i] & a[0]));
        end
        @(posedge sys_clk);
        unit_access <= 0;
        @(negedge sys_clk);
        check(irq, 1);
        check(unit_clk_en, g[0] & 32'h0011000f);
        bus(0, 12'h140, 32'h2);
        @(negedge sys_clk);
        check(irq, 0);
        $display("fault test done");
        @(posedge sys_clk);
        power_mode <= 2'h1;
        @(negedge sys_clk);
        check(unit_clk_en, g[0] & 32'h0011000f);
        bus(1, 12'h060, 32'h08000140);
        @(posedge sys_clk);
        @(negedge sys_clk);
        check(unit_clk_en, g[1] & 32'h0011000f);
        @(posedge sys_clk);
        power_mode <= 2'h2;
        @(negedge sys_clk);
        check(unit_clk_en, g[2] & 32'h0011000f);
        bus(0, 12'h140, 32'h1);
        bus(0, 12'h064, 32'h00001843);
        bus(0, 12'h7fc, 32'h0);
        repeat (3) @(posedge sys_clk);
        $display("mode test done");
        summarize;
    end
    initial
    begin
        #20000;
        n_fail = n_fail + 1;
        summarize;
    end
endmodule // pcg_clock_gate_test
